/* design/cswd_decoder.sv */
/*
  Chip select and wait state decoder: forms addresses, holds the five select
  control registers in I/O space, drives active-low selects for the length of
  each memory or peripheral cycle that hits a window and reports strap-controlled watchdog and EEPROM state.
  Assumes a processor bus that presents one cycle at a time on cycStart and
  waits for cycDone, and board pins that are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module cswd_decoder #(
  parameter int PAGE_W = cswd_pkg::EEP_PAGE_W,
  parameter int LOW_PAGES = cswd_pkg::EEP_LOW_PAGES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic cycStart,
  input wire logic cycIo,
  input wire logic cycWrite,
  input wire logic [15:0] cycSegment,
  input wire logic [15:0] cycOffset,
  input wire logic [15:0] cycWdata,
  output logic cycDone,
  output logic [15:0] cycRdata,
  output logic [19:0] cycAddr,
  output logic upperMemSel_n,
  output logic lowerMemSel_n,
  output logic midMemSel_n,
  output logic [cswd_pkg::LOW_GROUP_N-1:0] lowPeriphSel_n,
  output logic [cswd_pkg::HIGH_GROUP_N-1:0] highPeriphSel_n,
  input wire logic extReady,
  input wire logic watchdogStrap,
  input wire logic eepromProtectStrap,
  input wire logic eepromWrReq,
  input wire logic [PAGE_W-1:0] eepromWrPage,
  output logic eepromWrGrant,
  output logic watchdogActive,
  output logic [31:0] pioOutEnable
);
  import cswd_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    cswd_state_t fsm;
    logic [3:0] waitCnt;
    logic needReady;
    logic [2:0] memSel;
    logic [LOW_GROUP_N+HIGH_GROUP_N-1:0] perSel;
    logic [15:0] upperCtrl;
    logic [15:0] lowerCtrl;
    logic [15:0] periphCtrl;
    logic [15:0] midMemCtrl;
    logic [15:0] midPerCtrl;
    logic [15:0] rdata;
    logic done;
    logic [19:0] addr;
    logic [31:0] pioDir;
    logic wdActive;
    logic eepGrant;
  } cswd_core_t;

  cswd_core_t st;
  cswd_core_t next_st;

  logic [SYNC_W-1:0] pinSync;
  logic readySync;
  logic wdStrapSync;
  logic eepStrapSync;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  cswd_sync #(
    .W(SYNC_W)
  ) pinSyncInst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .asyncIn({eepromProtectStrap, watchdogStrap, extReady}),
    .syncOut(pinSync)
  );

  assign readySync = pinSync[0];
  assign wdStrapSync = pinSync[1];
  assign eepStrapSync = pinSync[2];

  // ==========================================================================
  // Address forming and decode
  // ==========================================================================
  logic [19:0] physAddr;
  logic upperHit;
  logic lowerHit;
  logic midHit;
  logic [MID_BASE_W-1:0] midDelta;
  logic ioBaseHit;
  logic [2:0] ioBlock;
  logic [LOW_GROUP_N-1:0] lowHit;
  logic [HIGH_GROUP_N-1:0] highHit;
  logic regHit;

  assign physAddr = {cycSegment, 4'h0} + {4'h0, cycOffset};

  assign upperHit = st.upperCtrl[SEL_EN_BIT] &&
    (physAddr[19:16] >= st.upperCtrl[UPPER_BASE_LSB +: NIBBLE_W]);
  assign lowerHit = st.lowerCtrl[SEL_EN_BIT] &&
    (physAddr[19:16] <= st.lowerCtrl[LOWER_TOP_LSB +: NIBBLE_W]);
  assign midDelta = physAddr[19:13] - st.midMemCtrl[MID_BASE_LSB +: MID_BASE_W];
  assign midHit = st.midMemCtrl[SEL_EN_BIT] &&
    (physAddr[19:13] >= st.midMemCtrl[MID_BASE_LSB +: MID_BASE_W]) &&
    (midDelta < st.midPerCtrl[MID_SIZE_LSB +: MID_SIZE_W]);

  assign ioBaseHit = (cycOffset[15:11] == st.periphCtrl[PER_BASE_LSB +: PER_BASE_W]);
  assign ioBlock = cycOffset[10:8];

  // Each low-group select owns one 0x100 block above the programmed base.
  always_comb begin
    for (int i = 0; i < LOW_GROUP_N; i++) begin
      lowHit[i] = st.periphCtrl[LOW_GRP_EN_BIT] && ioBaseHit &&
        (ioBlock == 3'(i));
    end
  end

  assign highHit[0] = st.midPerCtrl[HIGH_GRP_EN_BIT] && ioBaseHit &&
    (ioBlock == HIGH_BLOCK0);
  assign highHit[1] = st.midPerCtrl[HIGH_GRP_EN_BIT] && ioBaseHit &&
    (ioBlock == HIGH_BLOCK1);

  // Register offsets fall in block 7 of their base, which no peripheral select decodes, so the two never overlap.
  assign regHit = (cycOffset == UPPER_MEM_CTRL_ADDR) ||
    (cycOffset == LOWER_MEM_CTRL_ADDR) ||
    (cycOffset == PERIPH_BASE_CTRL_ADDR) ||
    (cycOffset == MID_MEM_CTRL_ADDR) ||
    (cycOffset == MID_PERIPH_CTRL_ADDR);

  // ==========================================================================
  // Wait counts per select
  // ==========================================================================
  // Memory selects take their two-bit count directly; the low group goes
  // through the coded I/O wait table so that slow peripherals can be served.
  logic [3:0] upperWait;
  logic [3:0] lowerWait;
  logic [3:0] midWait;
  logic [3:0] lowGrpWait;
  logic [3:0] highGrpWait;

  assign upperWait = {2'b00, st.upperCtrl[MEM_WAIT_LSB +: MEM_WAIT_W]};
  assign lowerWait = {2'b00, st.lowerCtrl[MEM_WAIT_LSB +: MEM_WAIT_W]};
  assign midWait = {2'b00, st.midMemCtrl[MEM_WAIT_LSB +: MEM_WAIT_W]};
  assign lowGrpWait = cswd_io_waits(st.periphCtrl[IO_WAIT_LSB +: IO_WAIT_W]);
  assign highGrpWait = {2'b00, st.midPerCtrl[MEM_WAIT_LSB +: MEM_WAIT_W]};

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.eepGrant = 1'b0;
    next_st.wdActive = wdStrapSync;
    if (eepromWrReq) begin
      next_st.eepGrant = !(eepStrapSync && (eepromWrPage < PAGE_W'(LOW_PAGES)));
    end
    case (st.fsm)
      CSWD_IDLE: begin
        if (cycStart) begin
          next_st.fsm = CSWD_ACTIVE;
          next_st.waitCnt = 4'h0;
          next_st.needReady = 1'b0;
          next_st.memSel = 3'b000;
          next_st.perSel = '0;
          next_st.rdata = 16'h0000;
          if (cycIo) begin
            // I/O space is decoded from the offset alone.
            next_st.addr = {4'h0, cycOffset};
            if (regHit) begin
              // Register accesses finish with no waits and no select.
              case (cycOffset)
                UPPER_MEM_CTRL_ADDR: begin
                  next_st.rdata = st.upperCtrl;
                  if (cycWrite) begin
                    next_st.upperCtrl = cycWdata;
                  end
                end
                LOWER_MEM_CTRL_ADDR: begin
                  next_st.rdata = st.lowerCtrl;
                  if (cycWrite) begin
                    next_st.lowerCtrl = cycWdata;
                  end
                end
                PERIPH_BASE_CTRL_ADDR: begin
                  next_st.rdata = st.periphCtrl;
                  if (cycWrite) begin
                    next_st.periphCtrl = cycWdata;
                  end
                end
                MID_MEM_CTRL_ADDR: begin
                  next_st.rdata = st.midMemCtrl;
                  if (cycWrite) begin
                    next_st.midMemCtrl = cycWdata;
                  end
                end
                default: begin
                  next_st.rdata = st.midPerCtrl;
                  if (cycWrite) begin
                    next_st.midPerCtrl = cycWdata;
                  end
                end
              endcase
            end else if (|lowHit) begin
              next_st.perSel = {2'b00, lowHit};
              next_st.waitCnt = lowGrpWait;
            end else if (|highHit) begin
              next_st.perSel = {highHit, 4'h0};
              next_st.waitCnt = highGrpWait;
            end
          end else begin
            next_st.addr = physAddr;
            // The mid-range window sits inside the ROM range, so it wins.
            if (midHit) begin
              next_st.memSel = 3'b100;
              next_st.waitCnt = midWait;
            end else if (upperHit) begin
              next_st.memSel = 3'b001;
              next_st.waitCnt = upperWait;
            end else if (lowerHit) begin
              next_st.memSel = 3'b010;
              next_st.waitCnt = lowerWait;
              next_st.needReady = !st.lowerCtrl[IGNORE_READY_BIT];
            end
            // With no hit nothing is selected and read data stays zero.
          end
        end
      end
      // Ready comes through the synchroniser, so a stall is seen two edges late.
      CSWD_ACTIVE: begin
        if (st.waitCnt != 4'h0) begin
          next_st.waitCnt = st.waitCnt - 4'h1;
        end else if (!st.needReady || readySync) begin
          next_st.fsm = CSWD_IDLE;
          next_st.done = 1'b1;
          next_st.memSel = 3'b000;
          next_st.perSel = '0;
          next_st.needReady = 1'b0;
        end
      end
      default: begin
        next_st.fsm = CSWD_IDLE;
        next_st.memSel = 3'b000;
        next_st.perSel = '0;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.upperCtrl <= UPPER_MEM_CTRL_RST;
      st.lowerCtrl <= LOWER_MEM_CTRL_RST;
      st.periphCtrl <= PERIPH_BASE_CTRL_RST;
      st.midMemCtrl <= MID_MEM_CTRL_RST;
      st.midPerCtrl <= MID_PERIPH_CTRL_RST;
      st.pioDir <= PIO_OUT_DEFAULT;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Selects are inverted flop outputs, so they cannot glitch between cycles.
  assign upperMemSel_n = ~st.memSel[0];
  assign lowerMemSel_n = ~st.memSel[1];
  assign midMemSel_n = ~st.memSel[2];
  assign lowPeriphSel_n = ~st.perSel[LOW_GROUP_N-1:0];
  assign highPeriphSel_n = ~st.perSel[LOW_GROUP_N +: HIGH_GROUP_N];
  assign cycDone = st.done;
  assign cycRdata = st.rdata;
  assign cycAddr = st.addr;
  assign eepromWrGrant = st.eepGrant;
  assign watchdogActive = st.wdActive;
  assign pioOutEnable = st.pioDir;

endmodule

/* design/cswd_sync.sv */
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the pins are quasi-static or independent bits.
*/
`timescale 1ns/1ps
module cswd_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } cswd_sync_t;

  cswd_sync_t st;
  cswd_sync_t next_st;

  // ==========================================================================
  // Two stages; only the second stage is seen outside.
  // ==========================================================================
  always_comb begin
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign syncOut = st.stage2;

endmodule

/* include/cswd_pkg.sv */
/*
  Constants, field layout, reset values and state encoding for the chip select
  and wait state decoder. Assumes a 16-bit processor bus with 20-bit memory
  addresses and 16-bit I/O addresses, and nothing else of its surroundings.
*/
package cswd_pkg;

  // ==========================================================================
  // Register offsets in I/O space
  // ==========================================================================
  localparam logic [15:0] UPPER_MEM_CTRL_ADDR = 16'hffa0;
  localparam logic [15:0] LOWER_MEM_CTRL_ADDR = 16'hffa2;
  localparam logic [15:0] PERIPH_BASE_CTRL_ADDR = 16'hffa4;
  localparam logic [15:0] MID_MEM_CTRL_ADDR = 16'hffa6;
  localparam logic [15:0] MID_PERIPH_CTRL_ADDR = 16'hffa8;

  // ==========================================================================
  // Reset values, equal to the default start-up configuration
  // ==========================================================================
  localparam logic [15:0] UPPER_MEM_CTRL_RST = 16'h80bf;
  localparam logic [15:0] LOWER_MEM_CTRL_RST = 16'h7fbf;
  localparam logic [15:0] PERIPH_BASE_CTRL_RST = 16'h007f;
  localparam logic [15:0] MID_MEM_CTRL_RST = 16'h81ff;
  localparam logic [15:0] MID_PERIPH_CTRL_RST = 16'ha0bf;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SEL_EN_BIT = 7;
  localparam int MEM_WAIT_LSB = 0;
  localparam int MEM_WAIT_W = 2;
  localparam int PSEUDO_STATIC_BIT = 6;
  localparam int IGNORE_READY_BIT = 2;
  localparam int UPPER_BASE_LSB = 12;
  localparam int LOWER_TOP_LSB = 12;
  localparam int NIBBLE_W = 4;
  localparam int MID_BASE_LSB = 9;
  localparam int MID_BASE_W = 7;
  localparam int MID_SIZE_LSB = 8;
  localparam int MID_SIZE_W = 7;
  localparam int PER_BASE_LSB = 11;
  localparam int PER_BASE_W = 5;
  localparam int LOW_GRP_EN_BIT = 3;
  localparam int IO_WAIT_LSB = 0;
  localparam int IO_WAIT_W = 3;
  localparam int HIGH_GRP_EN_BIT = 7;
  localparam int SEG_SHIFT = 4;

  // ==========================================================================
  // Peripheral groups, pin defaults and strap behaviour
  // ==========================================================================
  localparam int LOW_GROUP_N = 4;
  localparam int HIGH_GROUP_N = 2;
  localparam logic [2:0] HIGH_BLOCK0 = 3'h5;
  localparam logic [2:0] HIGH_BLOCK1 = 3'h6;
  localparam logic [31:0] PIO_OUT_DEFAULT = 32'h00f2_1000;
  localparam int EEP_PAGE_W = 5;
  localparam int EEP_LOW_PAGES = 8;
  localparam int SYNC_W = 3;

  typedef enum logic [1:0] {
    CSWD_IDLE = 2'b00,
    CSWD_ACTIVE = 2'b01
  } cswd_state_t;

  // Maps the 3-bit I/O wait setting onto a wait state count.
  function automatic logic [3:0] cswd_io_waits(input logic [2:0] setting);
    logic [3:0] w;
    w = 4'h0;
    case (setting)
      3'h4: w = 4'h5;
      3'h5: w = 4'h7;
      3'h6: w = 4'h9;
      3'h7: w = 4'hf;
      default: w = {1'b0, setting};
    endcase
    return w;
  endfunction

endpackage

/* tb/cswd_decoder_monitor.sv */
/*
  Assertion checker for the chip select decoder, bound to its ports.
  Assumes one clock domain and the synchronous reset of the decoder.
*/
`timescale 1ns/1ps
module cswd_decoder_monitor #(
  parameter int PAGE_W = 5,
  parameter int LOW_PAGES = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic cycDone,
  input wire logic upperMemSel_n,
  input wire logic lowerMemSel_n,
  input wire logic midMemSel_n,
  input wire logic [cswd_pkg::LOW_GROUP_N-1:0] lowPeriphSel_n,
  input wire logic [cswd_pkg::HIGH_GROUP_N-1:0] highPeriphSel_n,
  input wire logic eepromWrReq,
  input wire logic [PAGE_W-1:0] eepromWrPage,
  input wire logic eepromWrGrant,
  input wire logic watchdogStrap,
  input wire logic watchdogActive,
  input wire logic [31:0] pioOutEnable
);
  import cswd_pkg::*;
  logic [2:0] upCnt;
  logic selIdle;
  assign selIdle = upperMemSel_n & lowerMemSel_n & midMemSel_n & (&lowPeriphSel_n)
    & (&highPeriphSel_n);
  // Straps need a few clean edges after reset before they can be compared.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      upCnt <= 3'h0;
    end else if (clkEn && upCnt != 3'h7) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_mem_one_sel: assert property (
    $onehot0(~{upperMemSel_n, lowerMemSel_n, midMemSel_n}))
    else $error("two memory selects low");
  a_per_one_sel: assert property ($onehot0(~{lowPeriphSel_n, highPeriphSel_n}))
    else $error("two peripheral selects low");
  a_done_on_release: assert property ($rose(selIdle) |-> cycDone)
    else $error("select released without done");
  a_no_done_busy: assert property (!selIdle |-> !cycDone)
    else $error("done while a select is low");
  a_done_one_pulse: assert property (cycDone |=> !cycDone)
    else $error("done longer than one cycle");
  a_rom_sel_len: assert property ($fell(upperMemSel_n) |-> ##[1:4] upperMemSel_n)
    else $error("upper select too long");
  a_low_sel_len: assert property (
    $fell(&lowPeriphSel_n) |-> ##[1:16] (&lowPeriphSel_n))
    else $error("low group select too long");
  a_high_sel_len: assert property (
    $fell(&highPeriphSel_n) |-> ##[1:4] (&highPeriphSel_n))
    else $error("high group select too long");
  a_grant_cause: assert property (eepromWrGrant |-> $past(eepromWrReq))
    else $error("grant without request");
  a_page_high: assert property (
    clkEn && eepromWrReq && eepromWrPage >= LOW_PAGES |=> eepromWrGrant)
    else $error("high page write refused");
  a_wdog_follow: assert property (
    (upCnt == 3'h7 && $stable(watchdogStrap)) [*4] |-> watchdogActive == watchdogStrap)
    else $error("watchdog state differs from strap");
  a_pio_fixed: assert property (pioOutEnable == PIO_OUT_DEFAULT)
    else $error("pin directions differ from default");
  c_rom: cover property ($fell(upperMemSel_n));
  c_high: cover property ($fell(highPeriphSel_n[1]));
  c_grant: cover property (eepromWrGrant);
endmodule
bind cswd_decoder cswd_decoder_monitor #(.PAGE_W(PAGE_W), .LOW_PAGES(LOW_PAGES))
  cswd_decoder_monitor_i (
  .ref_clk, .sys_rst, .clkEn, .cycDone, .upperMemSel_n, .lowerMemSel_n, .midMemSel_n,
  .lowPeriphSel_n, .highPeriphSel_n, .eepromWrReq, .eepromWrPage, .eepromWrGrant,
  .watchdogStrap, .watchdogActive, .pioOutEnable
);

/* tb/cswd_far_side.sv */
/*
  Far side model: SRAM that can stall its ready line while selected.
  Assumes the decoder's lower select and a stall request from the bench.
*/
`timescale 1ns/1ps
module cswd_far_side (
  input wire logic ref_clk,
  input wire logic lowerMemSel_n,
  input wire logic stall,
  output logic extReady
);
  logic flip;
  initial flip = 1'b0;
  // A released ready line floats, so it shows a changing pattern, not a level.
  always @(posedge ref_clk) begin
    flip <= ~flip;
  end
  // A slow SRAM holds ready low for its whole select.
  assign extReady = (stall && !lowerMemSel_n) ? 1'b0 : flip;
endmodule

/* tb/testbench.sv */
/*
  Self-checking bench for the chip select decoder.
  Assumes the far side model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module testbench;
  import cswd_pkg::*;
  logic ref_clk, sys_rst, clkEn, cycStart, cycIo, cycWrite, extReady, stall;
  logic watchdogStrap, eepromProtectStrap, eepromWrReq, eepromWrGrant, watchdogActive;
  logic cycDone, upperMemSel_n, lowerMemSel_n, midMemSel_n;
  logic [15:0] cycSegment, cycOffset, cycWdata, cycRdata, rd, off, sg;
  logic [4:0] eepromWrPage;
  logic [3:0] lowPeriphSel_n;
  logic [1:0] highPeriphSel_n;
  logic [19:0] cycAddr, a, ea;
  logic [31:0] pioOutEnable;
  logic [8:0] s, es;
  logic ws;
  int failures, cmp_count, w;
  logic [15:0] rv[5] = '{UPPER_MEM_CTRL_RST, LOWER_MEM_CTRL_RST, PERIPH_BASE_CTRL_RST,
    MID_MEM_CTRL_RST, MID_PERIPH_CTRL_RST};
  logic [19:0] cor[6] = '{20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000, 20'hfffff, 20'h00000};
  cswd_decoder cswd_decoder_i (.ref_clk, .sys_rst, .clkEn, .cycStart, .cycIo, .cycWrite,
    .cycSegment, .cycOffset, .cycWdata, .cycDone, .cycRdata, .cycAddr, .upperMemSel_n,
    .lowerMemSel_n, .midMemSel_n, .lowPeriphSel_n, .highPeriphSel_n, .extReady,
    .watchdogStrap, .eepromProtectStrap, .eepromWrReq, .eepromWrPage, .eepromWrGrant,
    .watchdogActive, .pioOutEnable);
  cswd_far_side cswd_far_side_i (.ref_clk, .lowerMemSel_n, .stall, .extReady);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Expectations
  // ==========================================================================
  // Select vector order: upper, lower, mid, low group 3..0, high group 6..5.
  function automatic logic [8:0] memSel(input logic [19:0] x);
    if (x[19:18] == 2'h2) return 9'h1bf;
    if (x[19]) return 9'h0ff;
    return 9'h17f;
  endfunction
  function automatic logic [8:0] ioSel(input logic [15:0] x);
    logic [8:0] r;
    r = 9'h1ff;
    if (x[15:11] == 5'h0 && !x[10]) r[2 + x[9:8]] = 1'b0;
    if (x[15:11] == 5'h0 && x[10:8] == 3'h5) r[0] = 1'b0;
    if (x[15:11] == 5'h0 && x[10:8] == 3'h6) r[1] = 1'b0;
    return r;
  endfunction
  function automatic int ioW(input int c);
    int t[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
    return t[c];
  endfunction
  // ==========================================================================
  // Bus cycle, comparison and closing
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input logic io, wr, input logic [15:0] seg, ofs, wd);
    cycStart <= 1'b1;
    cycIo <= io;
    cycWrite <= wr;
    cycSegment <= seg;
    cycOffset <= ofs;
    cycWdata <= wd;
    @(posedge ref_clk);
    cycStart <= 1'b0;
    @(negedge ref_clk);
    s = {upperMemSel_n, lowerMemSel_n, midMemSel_n, lowPeriphSel_n, highPeriphSel_n};
    a = cycAddr;
    w = -1;
    while (cycDone !== 1'b1 && w < 40) begin
      @(negedge ref_clk);
      w++;
    end
    chk(cycDone, 1'b1);
    rd = cycRdata;
    @(posedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    {sys_rst, clkEn} = 2'b11;
    {cycStart, cycIo, cycWrite, stall, watchdogStrap, eepromProtectStrap, eepromWrReq} = '0;
    {cycSegment, cycOffset, cycWdata, eepromWrPage} = '0;
    void'($urandom(61955));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(pioOutEnable, PIO_OUT_DEFAULT);
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      cyc(1'b1, 1'b0, 16'h0, 16'hffa0 + 16'(2 * i), 16'h0);
      chk(rd, rv[i]);
      chk(s, 9'h1ff);
    end
    stall <= 1'b1;
    // The lower select must not wait on a stalled ready line.
    for (int i = 0; i < 40; i++) begin
      sg = (i < 6) ? cor[i][19:4] : 16'($urandom);
      off = (i < 6) ? {12'h0, cor[i][3:0]} : 16'($urandom);
      ea = (i < 6) ? cor[i] : ({sg, 4'h0} + {4'h0, off});
      cyc(1'b0, 1'($urandom), sg, off, 16'h0);
      chk(a, ea);
      chk(s, memSel(ea));
      chk(w, 3);
    end
    stall <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      off = (i < 8) ? {5'h0, 3'(i), 8'hff} : 16'($urandom_range(0, 16'h0fff));
      cyc(1'b1, 1'b0, 16'h0, off, 16'h0);
      es = ioSel(off);
      chk(s, es);
      chk(w, (es[5:2] != 4'hf) ? 15 : (es[1:0] != 2'h3) ? 3 : 0);
    end
    for (int c = 0; c < 8; c++) begin
      cyc(1'b1, 1'b1, 16'h0, 16'hffa4, 16'h0078 | 16'(c));
      cyc(1'b1, 1'b0, 16'h0, 16'h0100, 16'h0);
      chk(w, ioW(c));
      chk(s, 9'h1f7);
    end
    // A start given while the clock enable is low must be lost.
    clkEn <= 1'b0;
    cycStart <= 1'b1;
    cycIo <= 1'b1;
    cycWrite <= 1'b1;
    cycOffset <= UPPER_MEM_CTRL_ADDR;
    cycWdata <= 16'h0000;
    repeat (2) @(posedge ref_clk);
    cycStart <= 1'b0;
    clkEn <= 1'b1;
    @(posedge ref_clk);
    cyc(1'b1, 1'b0, 16'h0, UPPER_MEM_CTRL_ADDR, 16'h0);
    chk(rd, UPPER_MEM_CTRL_RST);
    cyc(1'b1, 1'b1, 16'h0, 16'hffa0, 16'h80bc);
    cyc(1'b0, 1'b0, 16'hf000, 16'h0, 16'h0);
    chk(w, 0);
    chk(s, 9'h0ff);
    cyc(1'b1, 1'b1, 16'h0, 16'hffa2, 16'h3fbf);
    cyc(1'b0, 1'b0, 16'h5000, 16'h0, 16'h0);
    chk(s, 9'h1ff);
    chk(rd, 16'h0);
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      ws = 1'($urandom);
      watchdogStrap <= ws;
      eepromProtectStrap <= 1'(p);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(watchdogActive, ws);
      for (int g = 0; g < 32; g++) begin
        @(posedge ref_clk);
        eepromWrReq <= 1'b1;
        eepromWrPage <= 5'(g);
        @(posedge ref_clk);
        eepromWrReq <= 1'b0;
        @(negedge ref_clk);
        chk(eepromWrGrant, !(p == 1 && g < EEP_LOW_PAGES));
      end
    end
    end_of_test();
  end
endmodule
